/* File: include/dma_ctl_defs.svh */
// Port numbers, register indices, reset values and encodings of the DMA control block
`ifndef DMA_CTL_DEFS_SVH
`define DMA_CTL_DEFS_SVH
`define IDX_PORT 16'h0022
`define DAT_PORT 16'h0023
`define CFG_INDEX 8'h01
`define CMD_INDEX 8'h08
`define CFG_RESET 8'hc0
`define CMD_RESET 8'h08
`define RD_NONE 8'h00
`define WS_ZERO 2'h0
`define WS_ONE 2'h1
`define WS_MAX 2'h3
`endif

/* File: include/dma_ctl_pkg.sv */
// Types of the DMA timing and command control block
package dma_ctl_pkg;
   typedef struct packed {
      logic [1:0] cpu_ws;
      logic [1:0] ws16;
      logic [1:0] ws8;
      logic early_rd;
      logic fast_clk;
   } cfg_s;
   typedef struct packed {
      logic dack_hi;
      logic dreq_hi;
      logic ext_wr;
      logic rotate;
      logic normal;
      logic ctl_off;
      logic addr_hold;
      logic mem2mem;
   } cmd_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_S1 = 3'b001,
      ST_S2 = 3'b010,
      ST_SW = 3'b011,
      ST_S4 = 3'b100
   } dma_st_e;
   typedef struct packed {
      logic [7:0] index;
      cfg_s cfg;
      cmd_s cmd;
      logic [7:0] rdata;
      logic busy;
      logic [1:0] wcnt;
      logic ready;
      logic dreq_m;
      logic dreq_q;
      logic rdy_m;
      logic rdy_q;
      logic div;
      logic sel;
      logic tick;
      dma_st_e st;
      logic [1:0] dwait;
      logic dack;
      logic dack_pin;
      logic memr_n;
      logic memw_n;
      logic hold;
   } state_s;
endpackage : dma_ctl_pkg

/* File: verif/dma_ctl_test.sv */
// Self-checking bench for the DMA timing and command control block
`timescale 1ns/1ps
`default_nettype none
`include "dma_ctl_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module dma_ctl_test;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, req = 0, act_hi = 0, word = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata, q;
   logic [3:0] stall = 4'h0;
   logic [1:0] s2;
   logic ready, dack, rd_n, wr_n, clk_en, rot, norm, hold, m2m, dreq, iochrdy;
   logic [7:0] cmds [3] = '{8'h13, 8'h0a, 8'h09};
   int n_errors = 0, total_checks = 0, lat, n;
   // Clock at 200 MHz
   always #2.5 clk = ~clk;
   dma_ctl i_dut (.CLK(clk), .RESET_N(rst_n), .IO_ADDR(addr), .IO_WDATA(wdata), .IO_WR(wr),
      .IO_RD(rd), .IO_RDATA(rdata), .IO_READY(ready), .DREQ(dreq), .IOCHRDY(iochrdy),
      .WORD_XFER(word), .DACK(dack), .DMA_MEMORY_READ_STROBE_N(rd_n),
      .DMA_MEMORY_WRITE_STROBE_N(wr_n), .DMA_CLK_EN(clk_en), .DMA_ROTATE(rot),
      .DMA_NORMAL_TIMING(norm), .DMA_ADDR_HOLD(hold), .DMA_MEM2MEM(m2m));
   dma_requester i_agent (.clk(clk), .req(req), .act_hi(act_hi), .stall(stall),
      .dack(dack), .dreq(dreq), .iochrdy(iochrdy));
   // One port access, strobe held until the ready pulse is seen
   task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      lat = 0;
      do
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      while (ready !== 1'b1 && lat < 20);
      q = rdata;
      @(negedge clk);
      wr = 0;
      rd = 0;
   endtask : io
   task automatic wreg(input logic [7:0] i, input logic [7:0] d);
      io(`IDX_PORT, 1'b1, i);
      io(`DAT_PORT, 1'b1, d);
   endtask : wreg
   task automatic rreg(input logic [7:0] i);
      io(`IDX_PORT, 1'b1, i);
      io(`DAT_PORT, 1'b0, 8'h00);
   endtask : rreg
   // One request; n counts the cycles the acknowledge stays active
   task automatic burst();
      int t;
      t = 0;
      @(negedge clk);
      req = 1;
      while (dack !== act_hi && t < 40)
      begin
         @(negedge clk);
         t++;
      end
      req = 0;
      n = 0;
      while (dack === act_hi && n < 60)
      begin
         @(negedge clk);
         n++;
         if (n == 1)
            s2 = {rd_n, wr_n};
      end
   endtask : burst
   task automatic step(input logic [7:0] cf, input logic [7:0] cm, input int e);
      wreg(`CFG_INDEX, cf);
      wreg(`CMD_INDEX, cm);
      burst();
      `CHK(n, e)
   endtask : step
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // Watchdog, far beyond the several hundred cycles the tests need
   initial
   begin
      #50000;
      n_errors++;
      conclude();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(negedge clk);
      `CHK({rot, norm, hold, m2m, dack, rd_n, wr_n}, 7'b0100111)
      rst_n = 1;
      rreg(`CFG_INDEX);
      `CHK(q, 8'hc0)
      `CHK(lat, 5)
      rreg(`CMD_INDEX);
      `CHK(q, 8'h08)
      rreg(8'h05);
      `CHK(q, 8'h00)
      wreg(`CFG_INDEX, `CFG_RESET);
      for (int w = 0; w < 4; w++)
      begin
         wreg(`CFG_INDEX, {w[1:0], 6'h01});
         rreg(`CFG_INDEX);
         `CHK(q, {w[1:0], 6'h01})
         `CHK(lat, w + 2)
      end
      foreach (cmds[i])
      begin
         wreg(`CMD_INDEX, cmds[i]);
         `CHK({rot, norm, hold, m2m}, {cmds[i][4:3], &cmds[i][1:0], cmds[i][0]})
      end
      step(8'hc1, 8'h0c, 0);
      step(8'hc1, 8'h08, 4);
      `CHK(s2, 2'b11)
      step(8'hc3, 8'h28, 4);
      `CHK(s2, 2'b00)
      step(8'hcd, 8'h08, 7);
      word = 1;
      step(8'hf1, 8'h08, 7);
      step(8'he1, 8'h08, 6);
      step(8'he1, 8'h00, 5);
      step(8'he0, 8'h08, 12);
      // Halved clock: the tick alternates from one cycle to the next
      @(negedge clk);
      q[0] = clk_en;
      @(negedge clk);
      `CHK(clk_en, !q[0])
      stall = 4'h6;
      wreg(`CFG_INDEX, 8'he1);
      `CHK(clk_en, 1'b1)
      burst();
      // Six stalled cycles, two for the ready synchroniser and two through S4; the two waits fall inside the stall
      `CHK(n, 10)
      stall = 4'h0;
      // Switch both polarities with the controller held off
      wreg(`CMD_INDEX, 8'h0c);
      act_hi = 1;
      wreg(`CMD_INDEX, 8'hcc);
      `CHK(dack, 1'b0)
      step(8'he1, 8'hc8, 6);
      conclude();
   end
endmodule : dma_ctl_test
`default_nettype wire

/* File: verif/dma_requester.sv */
// Far-side requester model: request pin and ready line of a DMA peripheral
`timescale 1ns/1ps
`default_nettype none
module dma_requester (
   // Clock
   input wire logic clk,
   // Bench controls
   input wire logic req,
   input wire logic act_hi,
   input wire logic [3:0] stall,
   // Pins of the block
   input wire logic dack,
   output logic dreq,
   output logic iochrdy
);
   logic [3:0] cnt = 4'h0;
   // Request level follows the programmed sense
   assign dreq = req ~^ act_hi;
   // Count acknowledged cycles, saturating so a long cycle cannot wrap
   always @(posedge clk)
      if (dack !== act_hi)
         cnt <= 4'h0;
      else if (cnt != 4'hf)
         cnt <= cnt + 4'h1;
   // Hold the cycle off while the stall count runs
   assign iochrdy = (dack !== act_hi) || (cnt >= stall);
endmodule : dma_requester
`default_nettype wire

/* File: verilog/dma_ctl.sv */
// DMA timing configuration and command control with indexed register port
`timescale 1ns/1ps
`default_nettype none
`include "dma_ctl_defs.svh"
module dma_ctl (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Host I/O port
   input wire logic [15:0] IO_ADDR,
   input wire logic [7:0] IO_WDATA,
   input wire logic IO_WR,
   input wire logic IO_RD,
   output logic [7:0] IO_RDATA,
   output logic IO_READY,
   // Bus pins
   input wire logic DREQ,
   input wire logic IOCHRDY,
   input wire logic WORD_XFER,
   output logic DACK,
   output logic DMA_MEMORY_READ_STROBE_N,
   output logic DMA_MEMORY_WRITE_STROBE_N,
   // Subsystem controls
   output logic DMA_CLK_EN,
   output logic DMA_ROTATE,
   output logic DMA_NORMAL_TIMING,
   output logic DMA_ADDR_HOLD,
   output logic DMA_MEM2MEM
);
   import dma_ctl_pkg::*;

   state_s s;
   state_s n;
   logic take;
   logic req;
   logic go_s2;

   // Request taken only when idle and addressed to our two ports
   assign take = !s.busy && (IO_WR || IO_RD)
      && (IO_ADDR == `IDX_PORT || IO_ADDR == `DAT_PORT);
   // Request level after polarity selection
   assign req = s.cmd.dreq_hi ? s.dreq_q : !s.dreq_q;

   // Next state of the whole block
   always_comb
   begin
      n = s;
      go_s2 = 1'b0;
      n.dreq_m = DREQ;
      n.dreq_q = s.dreq_m;
      n.rdy_m = IOCHRDY;
      n.rdy_q = s.rdy_m;
      n.ready = 1'b0;
      // Host access, answered after the wait states
      if (take)
      begin
         n.busy = 1'b1;
         n.wcnt = s.cfg.cpu_ws;
         if (IO_WR && IO_ADDR == `IDX_PORT)
         begin
            n.index = IO_WDATA;
         end
         else if (IO_WR)
         begin
            if (s.index == `CFG_INDEX)
            begin
               n.cfg = cfg_s'(IO_WDATA);
            end
            else if (s.index == `CMD_INDEX)
            begin
               n.cmd = cmd_s'(IO_WDATA);
            end
         end
         else if (IO_ADDR == `IDX_PORT)
         begin
            n.rdata = s.index;
         end
         else if (s.index == `CFG_INDEX)
         begin
            n.rdata = s.cfg;
         end
         else if (s.index == `CMD_INDEX)
         begin
            n.rdata = s.cmd;
         end
         else
         begin
            n.rdata = `RD_NONE;
         end
      end
      else if (s.busy)
      begin
         if (s.wcnt == `WS_ZERO)
         begin
            n.busy = 1'b0;
            n.ready = 1'b1;
         end
         else
         begin
            n.wcnt = s.wcnt - `WS_ONE;
         end
      end
      // Select follows config only at a divided period end, so no short pulse
      n.div = !s.div;
      if (s.div)
      begin
         n.sel = s.cfg.fast_clk;
      end
      n.tick = n.sel || n.div;
      // Cycle sequencer advances on DMA clock ticks only
      if (s.tick)
      begin
         case (s.st)
            ST_IDLE:
            begin
               if (req && !s.cmd.ctl_off)
               begin
                  n.dack = 1'b1;
                  if (s.cmd.normal)
                  begin
                     n.st = ST_S1;
                  end
                  else
                  begin
                     go_s2 = 1'b1;
                  end
               end
            end
            ST_S1:
            begin
               go_s2 = 1'b1;
            end
            ST_S2:
            begin
               n.st = ST_SW;
               n.memr_n = 1'b0;
               n.memw_n = 1'b0;
               n.dwait = WORD_XFER ? s.cfg.ws16 : s.cfg.ws8;
            end
            ST_SW:
            begin
               if (s.dwait != `WS_ZERO)
               begin
                  n.dwait = s.dwait - `WS_ONE;
               end
               else if (s.rdy_q)
               begin
                  n.st = ST_S4;
                  n.memr_n = 1'b1;
                  n.memw_n = 1'b1;
               end
            end
            ST_S4:
            begin
               n.dack = 1'b0;
               n.st = ST_IDLE;
            end
            default:
            begin
               n.st = ST_IDLE;
               n.dack = 1'b0;
               n.memr_n = 1'b1;
               n.memw_n = 1'b1;
            end
         endcase
      end
      // Entry into S2: early read and extended write strobes
      if (go_s2)
      begin
         n.st = ST_S2;
         if (s.cfg.early_rd)
         begin
            n.memr_n = 1'b0;
         end
         if (s.cmd.ext_wr)
         begin
            n.memw_n = 1'b0;
         end
      end
      n.dack_pin = n.dack ^ !n.cmd.dack_hi;
      n.hold = n.cmd.addr_hold && n.cmd.mem2mem;
   end

   // State register
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         s <= '0;
         s.cfg <= cfg_s'(`CFG_RESET);
         s.cmd <= cmd_s'(`CMD_RESET);
         s.rdy_m <= 1'b1;
         s.rdy_q <= 1'b1;
         // Idle level of an active-low request, so no false request after reset
         s.dreq_m <= 1'b1;
         s.dreq_q <= 1'b1;
         s.st <= ST_IDLE;
         s.dack_pin <= 1'b1;
         s.memr_n <= 1'b1;
         s.memw_n <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // Outputs, all from flops
   assign IO_RDATA = s.rdata;
   assign IO_READY = s.ready;
   assign DACK = s.dack_pin;
   assign DMA_MEMORY_READ_STROBE_N = s.memr_n;
   assign DMA_MEMORY_WRITE_STROBE_N = s.memw_n;
   assign DMA_CLK_EN = s.tick;
   assign DMA_ROTATE = s.cmd.rotate;
   assign DMA_NORMAL_TIMING = s.cmd.normal;
   assign DMA_ADDR_HOLD = s.hold;
   assign DMA_MEM2MEM = s.cmd.mem2mem;

   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   a_index_write: assert property (
      take && IO_WR && IO_ADDR == `IDX_PORT |=> s.index == $past(IO_WDATA))
      else $error("index port write lost");
   a_cfg_index: assert property (
      take && IO_WR && IO_ADDR == `DAT_PORT && s.index == `CFG_INDEX
      |=> s.cfg == $past(IO_WDATA))
      else $error("config write lost");
   a_cpu_wait_max: assert property (
      take && s.cfg.cpu_ws == 2'b11 |-> !IO_READY [*5] ##1 IO_READY)
      else $error("four wait states not met");
   a_cpu_wait_min: assert property (
      take && s.cfg.cpu_ws == 2'b00 |-> ##1 !IO_READY ##1 IO_READY)
      else $error("one wait state not met");
   a_dma_wait_len: assert property (
      s.tick && s.st == ST_S2 && WORD_XFER && s.cfg.ws16 == 2'b11
      |=> s.st == ST_SW && s.dwait == 2'b11)
      else $error("word wait count wrong");
   a_rdy_extend: assert property (
      s.st == ST_SW && !s.rdy_q |=> s.st == ST_SW)
      else $error("cycle ended while not ready");
   a_no_short_clk: assert property (
      !DMA_CLK_EN |=> DMA_CLK_EN)
      else $error("DMA clock pulse lost");
   a_fast_clk: assert property (
      s.sel && $past(s.sel) |-> DMA_CLK_EN)
      else $error("full clock not continuous");
   a_disable_idle: assert property (
      s.st == ST_IDLE && s.cmd.ctl_off |=> s.st == ST_IDLE)
      else $error("cycle started while disabled");
   a_dack_pol: assert property (
      DACK == (s.dack ^ !s.cmd.dack_hi))
      else $error("acknowledge polarity wrong");
   a_early_read: assert property (
      s.st == ST_S2 && s.cfg.early_rd && $changed(s.st)
      |-> !DMA_MEMORY_READ_STROBE_N)
      else $error("early read not asserted");
   a_ext_write: assert property (
      s.st == ST_S2 && !s.cmd.ext_wr |-> DMA_MEMORY_WRITE_STROBE_N)
      else $error("write asserted early without extended write");

   c_cpu_read: cover property (take && IO_RD ##[1:6] IO_READY);
   c_dma_cycle: cover property (s.st == ST_SW ##[1:40] s.st == ST_IDLE);
   c_clk_switch: cover property (s.sel ##1 !s.sel);
   c_compressed: cover property (s.st == ST_IDLE && !s.cmd.normal ##1 s.st == ST_S2);
endmodule : dma_ctl
`default_nettype wire
